// [hdl/gpic_pkg.sv]
// Operation
// - Up to nineteen requests: thirteen external inputs plus internal peripheral sources.
// - Every source has a request flag gated by its own enable bit.
// - Cleared global enable in enable_reg_a blocks every source.
// - Group n: enable_reg_a first, enable_reg_c second, enable_reg_b last; enable_reg_d third in group five only.
// - Six fixed groups of sources, each listed in falling in-group priority.
// - In-group order is fixed: first column beats middle, middle beats last.
// - Each group level 0..3 comes from level_reg_hi and level_reg_lo bits.
// - Equal levels are resolved from group zero down to group five.
// - Pick highest level, then lowest group number, then best source inside.
// - Only a strictly higher level pre-empts a running service routine.
// - At most four routines in service, one per priority level.
// - External interrupt zero is the OR of serial, USB, endpoint and smartcard requests.
// - SPI and power-status requests stay out of external interrupt zero.
// - External interrupt one combines GPIO ports 0, 1 and 2.
// - Vectors 03h, 0Bh, 13h, 1Bh, 23h, 2Bh, 43h, 4Bh.
// - Vectors 53h, 5Bh, 63h, 6Bh, 83h, 8Bh, 93h, 9Bh, A3h, ABh, EBh.
// - Compare outputs zero to three also raise externals three to six.
// - Smartcard request merges both smart-card interface requests.
package gpic_pkg;
	localparam int NUM_SRC = 19;
	localparam int NUM_GRP = 6;
	localparam int NUM_LVL = 4;
	localparam int GIE_BIT = 7;
	localparam int RSV_EN_BIT = 5;
	localparam int GRP_TOP = 5;

	typedef logic [4:0] gpic_idx_t;
	typedef logic [1:0] gpic_lvl_t;
	typedef logic [7:0] gpic_vec_t;

	// Source indices, lowest index means highest priority inside a group.
	localparam int SRC_EXT0 = 0;
	localparam int SRC_RSVA = 1;
	localparam int SRC_EXT7 = 2;
	localparam int SRC_TMR0 = 3;
	localparam int SRC_EP1 = 4;
	localparam int SRC_SPI = 5;
	localparam int SRC_EXT1 = 6;
	localparam int SRC_EP2 = 7;
	localparam int SRC_EP3 = 8;
	localparam int SRC_TMR1 = 9;
	localparam int SRC_EP5 = 10;
	localparam int SRC_EP4 = 11;
	localparam int SRC_SER = 12;
	localparam int SRC_EP0 = 13;
	localparam int SRC_USB = 14;
	localparam int SRC_TMR2 = 15;
	localparam int SRC_CARD = 16;
	localparam int SRC_RSVB = 17;
	localparam int SRC_PWR = 18;

	// Entry point of each source, in source index order.
	localparam gpic_vec_t SRC_VEC [NUM_SRC] = '{
		8'h03, 8'h83, 8'h43, 8'h0B, 8'h8B, 8'h4B, 8'h13, 8'h93,
		8'h53, 8'h1B, 8'h9B, 8'h5B, 8'h23, 8'hA3, 8'h63, 8'h2B,
		8'hAB, 8'hEB, 8'h6B};

	// Members of each group as a mask over the source indices.
	localparam logic [NUM_SRC-1:0] GRP_MASK [NUM_GRP] = '{
		19'h0_0007, 19'h0_0038, 19'h0_01C0,
		19'h0_0E00, 19'h0_7000, 19'h7_8000};
endpackage

// [hdl/gpic_top.sv]
`timescale 1ns/1ps
`default_nettype none
module gpic_top
#(
	parameter bit CMP_HI_EN = 1'b0,
	parameter int NUM_SRC = 19
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic timer_zero_overflow,
	input wire logic timer_one_overflow,
	input wire logic timer_two_irq,
	input wire logic serial_irq,
	input wire logic spi_port_irq,
	input wire logic ext_irq_seven,
	input wire logic reserved_irq_a,
	input wire logic reserved_irq_b,
	input wire logic [2:0] gpio_port_irq,
	input wire logic endpoint_zero_irq,
	input wire logic endpoint_one_irq,
	input wire logic endpoint_two_irq,
	input wire logic endpoint_three_irq,
	input wire logic endpoint_four_irq,
	input wire logic endpoint_five_irq,
	input wire logic usb_irq,
	input wire logic power_event_irq,
	input wire logic card_one_irq,
	input wire logic card_two_irq,
	input wire logic compare_out_zero,
	input wire logic compare_out_one,
	input wire logic compare_out_two,
	input wire logic compare_out_three,
	input wire logic [7:0] enable_reg_a,
	input wire logic [5:0] enable_reg_b,
	input wire logic [5:0] enable_reg_c,
	input wire logic [7:0] enable_reg_d,
	input wire logic [5:0] level_reg_lo,
	input wire logic [5:0] level_reg_hi,
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic irq_req,
	output logic [7:0] irq_vector,
	output logic [1:0] irq_level,
	output logic [3:0] in_service
);
	// The source tables are fixed; any other count cannot be served.
	if (NUM_SRC != gpic_pkg::NUM_SRC)
	begin : g_bad_count
		$error("gpic_top supports exactly nineteen sources");
	end

	// Lowest set bit wins, because lower index means higher priority.
	function automatic gpic_pkg::gpic_idx_t first_src(
		input logic [18:0] m);
		gpic_pkg::gpic_idx_t r;
		r = '0;
		for (int i = gpic_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (m[i])
				r = gpic_pkg::gpic_idx_t'(i);
		end
		return r;
	endfunction

	// Returns {valid, level, group}; strict compare keeps lower groups.
	function automatic logic [5:0] best_grp(input logic [5:0] gp,
		input logic [11:0] lv);
		logic [5:0] r;
		r = '0;
		for (int g = 0; g < gpic_pkg::NUM_GRP; g++)
		begin
			if (gp[g] && (!r[5] || lv[2*g +: 2] > r[4:3]))
				r = {1'b1, lv[2*g +: 2], 3'(g)};
		end
		return r;
	endfunction

	// Returns {valid, level} of the highest level now in service.
	function automatic logic [2:0] top_of(input logic [3:0] s);
		logic [2:0] r;
		r = '0;
		for (int i = 0; i < gpic_pkg::NUM_LVL; i++)
		begin
			if (s[i])
				r = {1'b1, 2'(i)};
		end
		return r;
	endfunction

	// One-hot flag of a priority level; shared by the set and clear paths
	// so both always agree on which in-service bit a level owns.
	function automatic logic [3:0] lvl_onehot(
		input gpic_pkg::gpic_lvl_t l);
		return 4'h1 << l;
	endfunction

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic irq_req_q;
	logic irq_req_d;
	gpic_pkg::gpic_vec_t vec_q;
	gpic_pkg::gpic_lvl_t lvl_q;
	logic [3:0] inserv_q;
	logic [3:0] inserv_d;

	// Reset is asserted at once but released only after two clean edges.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// Merged external requests; upper compare outputs are gated off
	// in this version, so CMP_HI_EN stays low by default.
	wire logic ext_irq_zero;
	wire logic ext_irq_one;
	wire logic smartcard_irq;
	wire logic ext_three;
	wire logic ext_four;
	wire logic ext_five;
	wire logic ext_six;
	assign ext_irq_zero = serial_irq | usb_irq | endpoint_zero_irq |
		endpoint_one_irq | endpoint_two_irq | endpoint_three_irq |
		endpoint_four_irq | endpoint_five_irq | smartcard_irq;
	assign ext_irq_one = |gpio_port_irq;
	assign smartcard_irq = card_one_irq | card_two_irq;
	assign ext_three = endpoint_three_irq | compare_out_zero;
	assign ext_four = endpoint_four_irq | compare_out_one;
	assign ext_five = usb_irq | (compare_out_two & CMP_HI_EN);
	assign ext_six = power_event_irq | (compare_out_three & CMP_HI_EN);

	// Request flags in group and priority order.
	wire logic [18:0] req_w;
	assign req_w = {ext_six, reserved_irq_b, smartcard_irq,
		timer_two_irq, ext_five, endpoint_zero_irq, serial_irq,
		ext_four, endpoint_five_irq, timer_one_overflow, ext_three,
		endpoint_two_irq, ext_irq_one, spi_port_irq, endpoint_one_irq,
		timer_zero_overflow, ext_irq_seven, reserved_irq_a,
		ext_irq_zero};

	// Per-source enables; group five carries a fourth source, enabled from enable_reg_d.
	wire logic [18:0] en_w;
	for (genvar g = 0; g < gpic_pkg::GRP_TOP; g++)
	begin : g_en
		assign en_w[3*g] = enable_reg_a[g];
		assign en_w[3*g+1] = enable_reg_c[g];
		assign en_w[3*g+2] = enable_reg_b[g];
	end
	assign en_w[gpic_pkg::SRC_TMR2] = enable_reg_a[gpic_pkg::GRP_TOP];
	assign en_w[gpic_pkg::SRC_CARD] = enable_reg_c[gpic_pkg::GRP_TOP];
	assign en_w[gpic_pkg::SRC_RSVB] =
		enable_reg_d[gpic_pkg::RSV_EN_BIT];
	assign en_w[gpic_pkg::SRC_PWR] = enable_reg_b[gpic_pkg::GRP_TOP];

	wire logic [18:0] pend_w;
	assign pend_w = req_w & en_w;

	// Group pending bits and programmed levels.
	wire logic [5:0] gpend_w;
	wire logic [11:0] glvl_w;
	for (genvar g = 0; g < gpic_pkg::NUM_GRP; g++)
	begin : g_grp
		assign gpend_w[g] = |(pend_w & gpic_pkg::GRP_MASK[g]);
		assign glvl_w[2*g +: 2] = {level_reg_hi[g], level_reg_lo[g]};
	end

	// Winner: level first, group number second, source order last.
	wire logic [5:0] best_w;
	wire logic [2:0] win_grp_w;
	wire gpic_pkg::gpic_lvl_t win_lvl_w;
	wire gpic_pkg::gpic_idx_t win_src_w;
	assign best_w = best_grp(gpend_w, glvl_w);
	assign win_grp_w = best_w[2:0];
	assign win_lvl_w = best_w[4:3];
	assign win_src_w = first_src(pend_w &
		gpic_pkg::GRP_MASK[win_grp_w]);

	// A request passes only above the highest level in service.
	wire logic [2:0] top_w;
	wire logic above_w;
	wire logic grant_w;
	assign top_w = top_of(inserv_q);
	assign above_w = !top_w[2] || (win_lvl_w > top_w[1:0]);
	assign grant_w = irq_req_q && irq_ack;
	assign irq_req_d = enable_reg_a[gpic_pkg::GIE_BIT] && best_w[5] &&
		above_w && !grant_w;

	// Return retires the top level; a grant in the same edge still sets.
	wire logic [3:0] clr_w;
	wire logic [3:0] set_w;
	assign clr_w = (irq_return && top_w[2]) ? lvl_onehot(top_w[1:0]) :
		4'h0;
	assign set_w = grant_w ? lvl_onehot(lvl_q) : 4'h0;
	assign inserv_d = (inserv_q & ~clr_w) | set_w;

	// Request, vector and level are registered together so the core
	// always sees a matching pair on the edge where it acknowledges.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_req_q <= 1'b0;
			vec_q <= 8'h00;
			lvl_q <= 2'h0;
			inserv_q <= 4'h0;
		end
		else
		begin
			irq_req_q <= irq_req_d;
			vec_q <= gpic_pkg::SRC_VEC[win_src_w];
			lvl_q <= win_lvl_w;
			inserv_q <= inserv_d;
		end
	end

	assign irq_req = irq_req_q;
	assign irq_vector = vec_q;
	assign irq_level = lvl_q;
	assign in_service = inserv_q;

	// All checks run on the system clock and sleep while the internal
	// reset copy is held, so the release edges cannot raise false alarms.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// The core takes a vector on the edge where request and acknowledge
	// meet.
	sequence grant_s;
		irq_req && irq_ack;
	endsequence

	// No return from the core on this edge.
	sequence quiet_s;
		!irq_return;
	endsequence

	// A return that does not collide with a grant and has work to retire.
	sequence retire_s;
		irq_return && !(irq_req && irq_ack) && in_service != 4'h0;
	endsequence

	// Global enable clear keeps the request line low.
	global_off_a: assert property (
			!enable_reg_a[gpic_pkg::GIE_BIT] |=> !irq_req)
		else $error("request raised with global enable clear");

	// The granted level is marked in service on the next edge.
	ack_marks_a: assert property (
			grant_s and quiet_s |=> in_service[$past(irq_level)])
		else $error("granted level not marked in service");

	// A taken request is withdrawn at once, so it is never taken twice.
	ack_drops_a: assert property (
			grant_s |=> !irq_req)
		else $error("request still raised after grant");

	// Nesting only ever climbs to a strictly higher level.
	strict_nest_a: assert property (
			irq_req && in_service != 4'h0 |-> irq_level > top_w[1:0])
		else $error("request not above level in service");

	// A level already in service is never offered again.
	level_free_a: assert property (
			irq_req |-> !in_service[irq_level])
		else $error("request at level already in service");

	// The last source of group one only wins when the others are idle.
	fixed_order_a: assert property (
			irq_req &&
			irq_vector == gpic_pkg::SRC_VEC[gpic_pkg::SRC_SPI] |->
			!$past(pend_w[gpic_pkg::SRC_TMR0]) &&
			!$past(pend_w[gpic_pkg::SRC_EP1]))
		else $error("in-group order violated");

	// The offered level is the one the arbiter picked an edge earlier.
	top_level_a: assert property (
			irq_req |-> irq_level == $past(win_lvl_w) && $past(best_w[5]))
		else $error("winner not at the highest pending level");

	// A return with levels in service and no grant on the same edge retires exactly one level.
	ret_clears_a: assert property (
			retire_s |=>
			$countones(in_service) == $countones($past(in_service)) - 1)
		else $error("return did not retire one level");

	// A return while the top level is busy always frees that top level.
	ret_top_a: assert property (
			retire_s ##0 in_service[3] |=> !in_service[3])
		else $error("return did not retire the top level");

	// The merged request is only offered while its own enable is set.
	en_gates_a: assert property (
			irq_req &&
			irq_vector == gpic_pkg::SRC_VEC[gpic_pkg::SRC_EXT0] |->
			$past(enable_reg_a[gpic_pkg::SRC_EXT0]))
		else $error("disabled source granted");

	// A USB request alone must reach the core through the merged line.
	merged_usb_a: assert property (
			usb_irq && enable_reg_a[gpic_pkg::SRC_EXT0] &&
			enable_reg_a[gpic_pkg::GIE_BIT] && in_service == 4'h0 &&
			!(irq_req && irq_ack) |=> irq_req)
		else $error("merged request not raised");

	// A GPIO port two request must reach the core through its own line.
	gpio_line_a: assert property (
			gpio_port_irq[2] && enable_reg_a[gpic_pkg::SRC_TMR0 - 1] &&
			enable_reg_a[gpic_pkg::GIE_BIT] && in_service == 4'h0 &&
			!(irq_req && irq_ack) |=> irq_req)
		else $error("port request not raised");
endmodule
`default_nettype wire

// [bench/gpic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gpic_core_model
(
	input wire logic sys_clk,
	input wire logic irq_req,
	input wire logic [1:0] ack_wait,
	input wire logic ret_go,
	output logic irq_ack,
	output logic irq_return
);
	logic [1:0] wait_q;
	initial
	begin
		irq_ack = 1'b0;
		irq_return = 1'b0;
		wait_q = 2'h0;
	end
	// The core takes a vector only while one is offered, after a variable
	// delay, so a slow core still has to meet a request that stands.
	always @(negedge sys_clk)
	begin
		irq_ack <= 1'b0;
		irq_return <= ret_go;
		wait_q <= 2'h0;
		if (irq_req && !irq_ack && wait_q >= ack_wait)
			irq_ack <= 1'b1;
		else if (irq_req && !irq_ack)
			wait_q <= wait_q + 2'h1;
	end
endmodule
`default_nettype wire

// [bench/gpic_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module gpic_top_tb_top;
	logic sys_clk, rst_b, ret_go, irq_ack, irq_return, irq_req;
	logic [1:0] ack_wait, irq_level, lvl;
	logic [7:0] irq_vector, en_a, en_d;
	logic [5:0] en_b, en_c, lv_lo, lv_hi;
	logic [3:0] in_service;
	logic [24:0] req;
	logic [9:0] exp_q [$];
	int miscompares, tests_run, grants, gbase, seed;
	// Winner of each single input, with the merged request enabled or not.
	logic [7:0] exp_on [25] = '{8'h0B, 8'h1B, 8'h2B, 8'h03, 8'h4B, 8'h43,
		8'h83, 8'hEB, 8'h13, 8'h13, 8'h13, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
		8'h03, 8'h03, 8'h6B, 8'h03, 8'h03, 8'h53, 8'h5B, 8'h00, 8'h00};
	logic [7:0] exp_off [25] = '{8'h0B, 8'h1B, 8'h2B, 8'h23, 8'h4B, 8'h43,
		8'h83, 8'hEB, 8'h13, 8'h13, 8'h13, 8'hA3, 8'h8B, 8'h93, 8'h53, 8'h5B,
		8'h9B, 8'h63, 8'h6B, 8'hAB, 8'hAB, 8'h53, 8'h5B, 8'h00, 8'h00};
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	gpic_top #(.CMP_HI_EN(1'b0), .NUM_SRC(19)) dut_u (.sys_clk, .rst_b,
		.timer_zero_overflow(req[0]), .timer_one_overflow(req[1]),
		.timer_two_irq(req[2]), .serial_irq(req[3]), .spi_port_irq(req[4]),
		.ext_irq_seven(req[5]), .reserved_irq_a(req[6]),
		.reserved_irq_b(req[7]), .gpio_port_irq(req[10:8]),
		.endpoint_zero_irq(req[11]), .endpoint_one_irq(req[12]),
		.endpoint_two_irq(req[13]), .endpoint_three_irq(req[14]),
		.endpoint_four_irq(req[15]), .endpoint_five_irq(req[16]),
		.usb_irq(req[17]), .power_event_irq(req[18]), .card_one_irq(req[19]),
		.card_two_irq(req[20]), .compare_out_zero(req[21]),
		.compare_out_one(req[22]), .compare_out_two(req[23]),
		.compare_out_three(req[24]), .enable_reg_a(en_a), .enable_reg_b(en_b),
		.enable_reg_c(en_c), .enable_reg_d(en_d), .level_reg_lo(lv_lo),
		.level_reg_hi(lv_hi), .irq_ack, .irq_return, .irq_req, .irq_vector,
		.irq_level, .in_service);
	gpic_core_model core_u (.sys_clk, .irq_req, .ack_wait, .ret_go,
		.irq_ack, .irq_return);
	task automatic check(input string what, input logic [9:0] e,
		input logic [9:0] g);
		tests_run++;
		if (e !== g)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	// Each grant consumes the oldest noted winner; none noted means a stray.
	always @(posedge sys_clk)
		if (irq_req === 1'b1 && irq_ack === 1'b1)
		begin
			grants++;
			if (exp_q.size() == 0)
				check("stray grant", 10'h000, {irq_level, irq_vector});
			else
				check("level vector", exp_q.pop_front(),
					{irq_level, irq_vector});
		end
	task automatic note(input logic [1:0] l, input logic [7:0] v);
		gbase = grants;
		exp_q.push_back({l, v});
	endtask
	task automatic wait_grant;
		for (int k = 0; k < 8 && grants == gbase; k++)
			@(negedge sys_clk);
		check("granted", 10'h001, 10'(grants != gbase));
		@(negedge sys_clk);
	endtask
	task automatic ret;
		ret_go <= 1'b1;
		@(negedge sys_clk);
		ret_go <= 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic run(input int i, input logic [7:0] v);
		ack_wait <= 2'($random(seed));
		req[i] = 1'b1;
		if (v != 8'h00)
			note(2'h0, v);
		if (v != 8'h00)
			wait_grant();
		else
			repeat (6) @(negedge sys_clk);
		check("in service", 10'(v != 8'h00), 10'(in_service));
		req[i] = 1'b0;
		ret();
		check("retired", 10'h000, 10'(in_service));
	endtask
	task automatic pair(input int i, input int j, input logic [1:0] l,
		input logic [7:0] v);
		req[i] = 1'b1;
		req[j] = 1'b1;
		note(l, v);
		wait_grant();
		req = '0;
		ret();
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Grant waits give up after eight edges; a fixed span cuts any other hang short.
	initial
	begin
		#200000;
		miscompares++;
		finish_test();
	end
	initial
	begin
		{rst_b, ret_go, ack_wait, req, lv_lo, lv_hi} = '0;
		{en_a, en_b, en_c, en_d} = {8'hBF, 6'h3F, 6'h3F, 8'h20};
		{seed, grants, miscompares, tests_run} = {32'd2, 96'd0};
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < 25; i++)
			run(i, exp_on[i]);
		$display("test merged sources done");
		en_a = 8'hBE;
		for (int i = 0; i < 25; i++)
			run(i, exp_off[i]);
		pair(12, 4, 2'h0, 8'h8B);
		pair(8, 14, 2'h0, 8'h13);
		lvl = 2'($random(seed));
		lv_lo = {lvl[0], 1'b0, lvl[0], 3'b000};
		lv_hi = {lvl[1], 1'b0, lvl[1], 3'b000};
		pair(1, 2, lvl, 8'h1B);
		en_a = 8'h3F;
		run(0, 8'h00);
		$display("test order and masking done");
		en_a = 8'hBF;
		lv_lo = 6'b100010;
		lv_hi = 6'b100001;
		req[8] = 1'b1;
		note(2'h0, 8'h13);
		wait_grant();
		req[0] = 1'b1;
		note(2'h1, 8'h0B);
		wait_grant();
		req[5] = 1'b1;
		note(2'h2, 8'h43);
		wait_grant();
		req[2] = 1'b1;
		note(2'h3, 8'h2B);
		wait_grant();
		check("four levels", 10'h00F, 10'(in_service));
		lv_lo[3] = 1'b1;
		req = 25'h000_0002;
		repeat (4) @(negedge sys_clk);
		check("equal level held", 10'h000, 10'(irq_req));
		ret();
		ret();
		note(2'h1, 8'h1B);
		ret();
		wait_grant();
		check("after nest", 10'h003, 10'(in_service));
		req = '0;
		ret();
		ret();
		check("all retired", 10'h000, 10'(in_service));
		$display("test nesting done");
		finish_test();
	end
endmodule
`default_nettype wire
